// ==== svw_pkg.sv ====
// What this block does
// - Assert reset while supply is below threshold
// - Release only after hold time of good supply
// - Assert reset while manual reset held low
// - Manual reset release waits full hold time
// - Constant kick level for period asserts reset
// - Any asserted reset clears watchdog timer
// - Kick edges clear timer; processor toggles often
// - Floating kick disables watchdog reset
// - Push/pull output drives low or high
// - Active-high output is exact inverse
// - Open-drain pulls low, never drives high
// - Bidirectional line shared, either party pulls low
// - Watchdog restarts from zero on release
// - Unconnected kick is serviced internally
// - Ignore short manual reset glitches
`default_nettype none
package svw_pkg;
    // Internal timebase: one tick per microsecond at 50 MHz
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned TICK_NS       = 1000;
    localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
    // Manual reset glitch filter, 100 ns typical, rounded up
    localparam int unsigned GLITCH_NS     = 100;
    localparam int unsigned GLITCH_CYCLES =
        (GLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CNT_W         = 32;

    // Selectable hold time and watchdog period, in ticks (us)
    typedef enum logic [1:0] {HOLD_1MS, HOLD_20MS, HOLD_140MS, HOLD_1120MS} svw_hold_sel_t;
    typedef enum logic [1:0] {WD_6P3MS, WD_102MS, WD_1P6S, WD_25P6S} svw_wd_sel_t;

    localparam logic [CNT_W-1:0] HOLD_TICKS_1MS    = 32'h0000_03e8;
    localparam logic [CNT_W-1:0] HOLD_TICKS_20MS   = 32'h0000_4e20;
    localparam logic [CNT_W-1:0] HOLD_TICKS_140MS  = 32'h0002_22e0;
    localparam logic [CNT_W-1:0] HOLD_TICKS_1120MS = 32'h0011_17a0;
    localparam logic [CNT_W-1:0] WD_TICKS_6P3MS    = 32'h0000_189c;
    localparam logic [CNT_W-1:0] WD_TICKS_102MS    = 32'h0001_8e70;
    localparam logic [CNT_W-1:0] WD_TICKS_1P6S     = 32'h0018_6a00;
    localparam logic [CNT_W-1:0] WD_TICKS_25P6S    = 32'h0186_a000;

    // Output stage variants
    typedef enum logic [1:0] {OUT_PUSH_PULL, OUT_OPEN_DRAIN, OUT_BIDIR} svw_out_kind_t;

    function automatic logic [CNT_W-1:0] svw_hold_ticks(input svw_hold_sel_t s);
        case (s)
            HOLD_1MS:   return HOLD_TICKS_1MS;
            HOLD_20MS:  return HOLD_TICKS_20MS;
            HOLD_140MS: return HOLD_TICKS_140MS;
            default:    return HOLD_TICKS_1120MS;
        endcase
    endfunction : svw_hold_ticks

    function automatic logic [CNT_W-1:0] svw_wd_ticks(input svw_wd_sel_t s);
        case (s)
            WD_6P3MS: return WD_TICKS_6P3MS;
            WD_102MS: return WD_TICKS_102MS;
            WD_1P6S:  return WD_TICKS_1P6S;
            default:  return WD_TICKS_25P6S;
        endcase
    endfunction : svw_wd_ticks
endpackage : svw_pkg
`default_nettype wire

// ==== svw_tick.sv ====
`default_nettype none
module svw_tick
    import svw_pkg::*;
#(
    parameter int unsigned DIV = TICK_CYCLES
)(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Timebase enable
    output var  logic tick
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } svw_tick_state_t;

    svw_tick_state_t st_ff;
    svw_tick_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt >= CNT_W'(DIV - 1))
        begin
            nxt_st.cnt  = '0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign tick = st_ff.tick;
endmodule : svw_tick
`default_nettype wire

// ==== svw_glitch.sv ====
`default_nettype none
module svw_glitch
    import svw_pkg::*;
#(
    parameter int unsigned LEN = GLITCH_CYCLES
)(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Raw and filtered manual reset, active low
    input  wire logic raw_n,
    output var  logic clean_n
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       level;
    } svw_glitch_state_t;

    svw_glitch_state_t st_ff;
    svw_glitch_state_t nxt_st;

    // Low must persist past the glitch width; a high returns at once
    always_comb
    begin
        nxt_st = st_ff;
        if (raw_n)
        begin
            nxt_st.cnt   = '0;
            nxt_st.level = 1'b1;
        end
        else if (st_ff.cnt >= 8'(LEN))
        begin
            nxt_st.level = 1'b0;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st_ff.cnt   <= '0;
            st_ff.level <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign clean_n = st_ff.level;
endmodule : svw_glitch
`default_nettype wire

// ==== svw_supervisor.sv ====
`default_nettype none
module svw_supervisor
    import svw_pkg::*;
#(
    parameter svw_hold_sel_t HOLD_SEL = HOLD_140MS,
    parameter svw_wd_sel_t   WD_SEL   = WD_1P6S,
    parameter int unsigned   TICK_DIV = TICK_CYCLES
)(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Reset sources
    input  wire logic supply_good,
    input  wire logic manual_reset_n,
    input  wire logic watchdog_kick,
    input  wire logic watchdog_kick_oe,
    // Push/pull outputs
    output var  logic reset_out_n,
    output var  logic reset_out,
    // Open-drain line
    output var  logic reset_od_o,
    output var  logic reset_od_oe,
    // Bidirectional shared line
    input  wire logic reset_bidir_i,
    output var  logic reset_bidir_o,
    output var  logic reset_bidir_oe
);
    typedef struct packed {
        logic [CNT_W-1:0] hold_cnt;
        logic [CNT_W-1:0] wd_cnt;
        logic             kick_q;
        logic             wd_fire;
        logic             asserted;
    } svw_state_t;

    localparam logic [CNT_W-1:0] HOLD_LIM = svw_hold_ticks(HOLD_SEL);
    localparam logic [CNT_W-1:0] WD_LIM   = svw_wd_ticks(WD_SEL);

    svw_state_t st_ff;
    svw_state_t nxt_st;
    logic       tick;
    logic       mr_clean_n;
    logic       any_src;
    logic       ext_pull;

    svw_tick #(.DIV(TICK_DIV)) u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick)
    );

    svw_glitch u_glitch (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .raw_n   (manual_reset_n),
        .clean_n (mr_clean_n)
    );

    // Outside party pulling the shared line low while we release it
    assign ext_pull = !reset_bidir_i && !reset_bidir_oe;

    assign any_src = !supply_good || !mr_clean_n || st_ff.wd_fire
                     || ext_pull;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.kick_q  = watchdog_kick;
        nxt_st.wd_fire = 1'b0;
        if (any_src)
        begin
            // Any active source restarts the hold count
            nxt_st.asserted = 1'b1;
            nxt_st.hold_cnt = '0;
        end
        else if (st_ff.asserted)
        begin
            if (st_ff.hold_cnt >= HOLD_LIM)
            begin
                nxt_st.asserted = 1'b0;
                nxt_st.hold_cnt = '0;
            end
            else if (tick)
            begin
                nxt_st.hold_cnt = st_ff.hold_cnt + 1'b1;
            end
        end
        // Watchdog counts only while reset is released
        if (nxt_st.asserted || st_ff.asserted)
        begin
            nxt_st.wd_cnt = '0;
        end
        else if (!watchdog_kick_oe || watchdog_kick != st_ff.kick_q)
        begin
            // Floating kick is serviced internally each cycle
            nxt_st.wd_cnt = '0;
        end
        else if (st_ff.wd_cnt >= WD_LIM - 1'b1)
        begin
            nxt_st.wd_cnt  = '0;
            nxt_st.wd_fire = 1'b1;
        end
        else if (tick)
        begin
            nxt_st.wd_cnt = st_ff.wd_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            // Come up asserted so the hold time runs after power-on
            st_ff          <= '0;
            st_ff.asserted <= 1'b1;
            reset_out_n    <= 1'b0;
            reset_out      <= 1'b1;
            reset_od_o     <= 1'b0;
            reset_od_oe    <= 1'b1;
            reset_bidir_o  <= 1'b0;
            reset_bidir_oe <= 1'b1;
        end
        else
        begin
            st_ff          <= nxt_st;
            reset_out_n    <= !nxt_st.asserted;
            reset_out      <= nxt_st.asserted;
            reset_od_o     <= 1'b0;
            reset_od_oe    <= nxt_st.asserted;
            reset_bidir_o  <= 1'b0;
            reset_bidir_oe <= nxt_st.asserted;
        end
    end
endmodule : svw_supervisor
`default_nettype wire

// ==== svw_supervisor_sva.sv ====
`default_nettype none
module svw_supervisor_chk
    import svw_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Sources
    input wire logic supply_good,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick,
    input wire logic watchdog_kick_oe,
    // Outputs
    input wire logic reset_out_n,
    input wire logic reset_out,
    input wire logic reset_od_o,
    input wire logic reset_od_oe,
    input wire logic reset_bidir_i,
    input wire logic reset_bidir_o,
    input wire logic reset_bidir_oe
);
    // Sim build: one cycle a tick, 1 ms hold, 6.3 ms period
    localparam int unsigned HOLD_MIN = HOLD_TICKS_1MS - 10;
    localparam int unsigned WD_MAX   = WD_TICKS_6P3MS + 10;
    logic [31:0] quiet_cnt;
    logic [31:0] still_cnt;
    logic        kick_q;
    always_ff @(posedge clk_sys)
    begin
        kick_q    <= watchdog_kick;
        quiet_cnt <= (rst_n && supply_good && manual_reset_n && (reset_bidir_i || reset_bidir_oe))
                     ? quiet_cnt + 32'h1 : 32'h0;
        still_cnt <= (rst_n && reset_out_n && watchdog_kick_oe && kick_q == watchdog_kick)
                     ? still_cnt + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_SUP_LOW: assert property (!supply_good |-> ##[1:2] !reset_out_n)
        else $error("reset missing on low supply");
    AST_HOLD: assert property ($rose(reset_out_n) |-> quiet_cnt >= HOLD_MIN)
        else $error("reset released before hold time");
    AST_MR_LOW: assert property (!manual_reset_n [*8] |-> ##1 !reset_out_n)
        else $error("reset missing on manual low");
    AST_GLITCH: assert property (reset_out_n && manual_reset_n ##1 !manual_reset_n [*3]
        ##1 manual_reset_n |-> reset_out_n [*4])
        else $error("short manual pulse caused reset");
    AST_WD_MAX: assert property (still_cnt <= WD_MAX)
        else $error("watchdog did not fire in time");
    AST_INV: assert property (reset_out == !reset_out_n)
        else $error("reset outputs not inverse");
    AST_OD: assert property (!reset_od_o && reset_od_oe == !reset_out_n)
        else $error("open drain stage wrong");
    AST_BIDIR: assert property (!reset_bidir_o && reset_bidir_oe == !reset_out_n)
        else $error("bidir stage wrong");
endmodule : svw_supervisor_chk
bind svw_supervisor svw_supervisor_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .supply_good(supply_good), .manual_reset_n(manual_reset_n), .watchdog_kick(watchdog_kick),
    .watchdog_kick_oe(watchdog_kick_oe), .reset_out_n(reset_out_n), .reset_out(reset_out),
    .reset_od_o(reset_od_o), .reset_od_oe(reset_od_oe), .reset_bidir_i(reset_bidir_i),
    .reset_bidir_o(reset_bidir_o), .reset_bidir_oe(reset_bidir_oe));
`default_nettype wire

// ==== svw_cpu_model.sv ====
`default_nettype none
module svw_cpu_model
(
    // Clock
    input wire logic clk_sys,
    // Bench control
    input wire logic kick_en,
    input wire logic pull_req,
    // Supervisor side
    input wire logic reset_bidir_o,
    input wire logic reset_bidir_oe,
    output var logic watchdog_kick,
    output var logic reset_bidir_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] div = 12'h0;
    initial watchdog_kick = 1'h0;
    // Toggle every 4096 cycles, well inside the period
    always @(posedge clk_sys)
    begin
        div <= #1 div + 12'h1;
        if (kick_en && div == 12'hfff)
            watchdog_kick <= #1 ~watchdog_kick;
    end
    // Shared line with pull-up: either party pulls low
    assign reset_bidir_i = !((reset_bidir_oe && !reset_bidir_o) || pull_req);
endmodule : svw_cpu_model
`default_nettype wire

// ==== test_svw_supervisor.sv ====
`default_nettype none
module test_svw_supervisor
    import svw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = int'(HOLD_TICKS_1MS);
    localparam int WD   = int'(WD_TICKS_6P3MS);
    logic clk_sys = 1'h0, rst_n = 1'h0, supply_good = 1'h1, manual_reset_n = 1'h1;
    logic kick_oe = 1'h1, kick_en = 1'h1, pull_req = 1'h0;
    logic kick, bidir_i, out_n, out_h, od_o, od_oe, bd_o, bd_oe;
    logic [7:0] lfsr = 8'h1d;
    int miscompares = 0, total_checks = 0, cycles = 0, n;
    always #10 clk_sys = ~clk_sys;
    svw_cpu_model cpu (.clk_sys(clk_sys), .kick_en(kick_en), .pull_req(pull_req),
        .reset_bidir_o(bd_o), .reset_bidir_oe(bd_oe), .watchdog_kick(kick),
        .reset_bidir_i(bidir_i));
    svw_supervisor #(.HOLD_SEL(HOLD_1MS), .WD_SEL(WD_6P3MS), .TICK_DIV(1)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .supply_good(supply_good),
        .manual_reset_n(manual_reset_n), .watchdog_kick(kick), .watchdog_kick_oe(kick_oe),
        .reset_out_n(out_n), .reset_out(out_h), .reset_od_o(od_o), .reset_od_oe(od_oe),
        .reset_bidir_i(bidir_i), .reset_bidir_o(bd_o), .reset_bidir_oe(bd_oe));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step
    // Cycles until reset_out_n reaches lvl, bounded
    task automatic wait_lvl(input logic lvl);
        n = 0;
        while (out_n !== lvl && n < 9000)
        begin
            step(1);
            n++;
        end
    endtask : wait_lvl
    task automatic stay_up(input int k);
        logic ok;
        ok = 1'h1;
        repeat (k)
        begin
            step(1);
            if (out_n !== 1'h1)
                ok = 1'h0;
        end
        check("stay_up", ok, 1'h1);
    endtask : stay_up
    function automatic logic [7:0] next_rnd(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : next_rnd
    // Hold measured from the last source release; pre counts cycles already run
    function automatic logic hold_ok(input int seen, input int pre);
        return seen + pre >= HOLD - 10 && seen + pre < HOLD + 20;
    endfunction : hold_ok
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            miscompares++;
            stop_test();
        end
    end
    initial
    begin
        step(20);
        check("in_reset", out_n, 1'h0);
        check("in_reset_h", out_h, 1'h1);
        check("in_reset_od", od_oe, 1'h1);
        check("in_reset_bd", bd_oe, 1'h1);
        rst_n = 1'h1;
        wait_lvl(1'h1);
        check("pwr_hold", hold_ok(n, 0), 1'h1);
        check("rel_h", out_h, 1'h0);
        check("rel_od_o", od_o, 1'h0);
        check("rel_od_oe", od_oe, 1'h0);
        check("rel_bd_o", bd_o, 1'h0);
        check("rel_bd_oe", bd_oe, 1'h0);
        check("rel_line", bidir_i, 1'h1);
        $display("test power_up done");
        repeat (3)
        begin
            lfsr = next_rnd(lfsr);
            supply_good = 1'h0;
            step(2);
            check("sup_low", out_n, 1'h0);
            step(lfsr);
            supply_good = 1'h1;
            step(300);
            supply_good = lfsr[0];
            step(1);
            supply_good = 1'h1;
            wait_lvl(1'h1);
            // Without a dip the hold has already run 301 cycles before the wait
            check("sup_hold", hold_ok(n, lfsr[0] ? 301 : 0), 1'h1);
        end
        $display("test supply done");
        manual_reset_n = 1'h0;
        step(3);
        manual_reset_n = 1'h1;
        stay_up(10);
        manual_reset_n = 1'h0;
        step(8 + lfsr);
        check("mr_low", out_n, 1'h0);
        manual_reset_n = 1'h1;
        wait_lvl(1'h1);
        check("mr_hold", hold_ok(n, 0), 1'h1);
        $display("test manual done");
        stay_up(15000);
        // Stop right after a kick edge so the period starts at a known point
        @(kick);
        kick_en = 1'h0;
        repeat (2)
        begin
            wait_lvl(1'h0);
            check("wd_fire", n > WD - 100 && n < WD + 20, 1'h1);
            wait_lvl(1'h1);
            check("wd_hold", hold_ok(n, 0), 1'h1);
        end
        $display("test watchdog done");
        kick_oe = 1'h0;
        stay_up(WD + 2000);
        kick_oe = 1'h1;
        kick_en = 1'h1;
        $display("test float done");
        pull_req = 1'h1;
        step(4);
        check("ext_pull", out_n, 1'h0);
        check("ext_line", bidir_i, 1'h0);
        pull_req = 1'h0;
        wait_lvl(1'h1);
        check("ext_hold", hold_ok(n, 0), 1'h1);
        $display("test bidir done");
        stop_test();
    end
endmodule : test_svw_supervisor
`default_nettype wire
